// [core/dct_defines.vh]
`ifndef DCT_DEFINES_VH
`define DCT_DEFINES_VH

// Register byte offsets
`define DCT_OFF_CMD        8'h00
`define DCT_OFF_ADDR       8'h04
`define DCT_OFF_WCNT       8'h08
`define DCT_OFF_SEEK       8'h0C
`define DCT_OFF_STATUS     8'h10

// Command register fields
`define DCT_CMD_FN_LSB     0
`define DCT_CMD_FN_MSB     2
`define DCT_CMD_DRV_LSB    3
`define DCT_CMD_DRV_MSB    4
`define DCT_CMD_BYTE_BIT   5
`define DCT_CMD_IE_BIT     6

// Seek register fields
`define DCT_SEEK_DIFF_MSB  8
`define DCT_SEEK_DIR_BIT   9
`define DCT_SEEK_HEAD_BIT  10

// Function codes
`define DCT_FN_NOP         3'h0
`define DCT_FN_SEEK        3'h3
`define DCT_FN_RDHDR       3'h4
`define DCT_FN_RDDATA      3'h6
`define DCT_FN_RDNOCHK     3'h7

// Reset values
`define DCT_RST_CMD        7'h00
`define DCT_RST_ADDR       16'h0000
`define DCT_RST_WCNT       12'h000
`define DCT_RST_SEEK       11'h000

// Sector format counts, limits and CRC polynomial
`define DCT_BYTE_BITS      4'h8
`define DCT_WORD_BITS      4'hC
`define DCT_WORDS12        12'd170
`define DCT_SECTOR_BYTES   12'd256
`define DCT_CRC_BITS       12'd16
`define DCT_HDR_BITS       12'd48
`define DCT_ADDR_BITS      12'd16
`define DCT_SECTOR_LIMIT   6'h28
`define DCT_SEARCH_LIMIT   8'h50
`define DCT_CRC_POLY       16'h8005

`endif

// [core/dct_packer.v]
`timescale 1ns/1ps
`include "dct_defines.vh"

module dct_packer (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clear,
    input  wire        byte_mode,
    input  wire        bit_valid,
    input  wire        bit_in,
    output wire        word_valid,
    output wire [11:0] word_out
);
    reg  [11:0] acc_reg;
    reg  [11:0] acc_next;
    reg  [3:0]  nbit_reg;
    reg  [3:0]  nbit_next;
    reg  [11:0] cnt_reg;
    reg  [11:0] cnt_next;
    reg  [11:0] word_reg;
    reg  [11:0] word_next;
    reg         valid_reg;
    reg         valid_next;
    wire [3:0]  limit;
    wire [11:0] shifted;
    wire [11:0] pack_max;

    assign limit    = byte_mode ? `DCT_BYTE_BITS : `DCT_WORD_BITS;
    assign shifted  = {acc_reg[10:0], bit_in};
    assign pack_max = `DCT_WORDS12 * 12'd12;

    always @* begin
        acc_next   = acc_reg;
        nbit_next  = nbit_reg;
        cnt_next   = cnt_reg;
        word_next  = word_reg;
        valid_next = 1'b0;
        if (clear) begin
            acc_next  = 12'h000;
            nbit_next = 4'h0;
            cnt_next  = 12'h000;
        end else if (bit_valid) begin
            cnt_next = cnt_reg + 12'd1;
            // Tail bits past the last whole 12-bit word are dropped
            if (byte_mode || cnt_reg < pack_max) begin
                acc_next  = shifted; // MSB first, no gap at byte edges
                nbit_next = nbit_reg + 4'h1;
                if (nbit_reg + 4'h1 == limit) begin
                    nbit_next  = 4'h0;
                    valid_next = 1'b1;
                    if (byte_mode)
                        word_next = {4'h0, shifted[7:0]};
                    else
                        word_next = shifted;
                end
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_reg   <= 12'h000;
            nbit_reg  <= 4'h0;
            cnt_reg   <= 12'h000;
            word_reg  <= 12'h000;
            valid_reg <= 1'b0;
        end else begin
            acc_reg   <= acc_next;
            nbit_reg  <= nbit_next;
            cnt_reg   <= cnt_next;
            word_reg  <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign word_valid = valid_reg;
    assign word_out   = word_reg;
endmodule

// [core/dct_ctrl.v]
`timescale 1ns/1ps
`include "dct_defines.vh"

module dct_ctrl (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        irq,
    input  wire        disk_bit,
    input  wire        disk_bit_valid,
    input  wire        hdr_mark,
    input  wire        data_mark,
    output wire [1:0]  drive_sel,
    output wire [3:0]  seek_start,
    output wire [8:0]  seek_diff,
    output wire        seek_dir,
    output wire        seek_head,
    input  wire [3:0]  seek_done,
    output wire        dma_req,
    output wire [11:0] dma_word,
    input  wire        dma_ack
);
    localparam S_IDLE  = 3'd0;
    localparam S_WSEEK = 3'd1;
    localparam S_HDR   = 3'd2;
    localparam S_DWAIT = 3'd3;
    localparam S_DATA  = 3'd4;

    reg  [2:0]  state_reg;
    reg  [2:0]  state_next;
    reg  [6:0]  cmd_reg;
    reg  [6:0]  cmd_next;
    reg  [15:0] addr_reg;
    reg  [15:0] addr_next;
    reg  [11:0] wcnt_reg;
    reg  [11:0] wcnt_next;
    reg  [10:0] seek_reg;
    reg  [10:0] seek_next;
    reg         done_reg;
    reg         done_next;
    reg  [4:0]  err_reg;
    reg  [4:0]  err_next;
    reg  [3:0]  seeking_reg;
    reg  [3:0]  start_reg;
    reg  [3:0]  start_next;
    reg  [11:0] bcnt_reg;
    reg  [11:0] bcnt_next;
    reg  [15:0] crc_reg;
    reg  [15:0] crc_next;
    reg  [15:0] hdr_reg;
    reg  [15:0] hdr_next;
    reg  [7:0]  search_reg;
    reg  [7:0]  search_next;
    reg         pk_clear;
    reg         dreq_reg;
    reg         dreq_next;
    reg  [11:0] dword_reg;
    reg  [11:0] dword_next;
    reg  [31:0] rdata_reg;
    reg  [31:0] rdata_next;

    wire [2:0]  fn;
    wire [1:0]  drv;
    wire        byte_mode;
    wire        wr_en;
    wire        rd_setup;
    wire        mapped;
    wire        cmd_wr;
    wire        busy;
    wire        crc_fb;
    wire [15:0] crc_step;
    wire [15:0] hdr_shift;
    wire [11:0] data_bits;
    wire [11:0] sector_bits;
    wire        feed;
    wire        pk_valid;
    wire [11:0] pk_word;
    wire [5:0]  sector_inc;
    wire        ack_ok;
    wire        pk_word_valid;
    wire [3:0]  seeking_next;

    assign fn        = cmd_reg[`DCT_CMD_FN_MSB:`DCT_CMD_FN_LSB];
    assign drv       = cmd_reg[`DCT_CMD_DRV_MSB:`DCT_CMD_DRV_LSB];
    assign byte_mode = cmd_reg[`DCT_CMD_BYTE_BIT];
    assign busy      = (state_reg != S_IDLE);
    assign mapped    = (paddr == `DCT_OFF_CMD) || (paddr == `DCT_OFF_ADDR) ||
                       (paddr == `DCT_OFF_WCNT) || (paddr == `DCT_OFF_SEEK) ||
                       (paddr == `DCT_OFF_STATUS);
    assign wr_en     = psel & penable & pwrite & mapped;
    assign rd_setup  = psel & ~penable & ~pwrite;
    assign cmd_wr    = wr_en & (paddr == `DCT_OFF_CMD) & ~busy;
    assign pready    = 1'b1;
    assign pslverr   = psel & penable & ~mapped;
    assign prdata    = rdata_reg;
    assign irq       = done_reg & cmd_reg[`DCT_CMD_IE_BIT];

    assign crc_fb      = crc_reg[15] ^ disk_bit;
    assign crc_step    = {crc_reg[14:0], 1'b0} ^ (crc_fb ? `DCT_CRC_POLY : 16'h0000);
    assign hdr_shift   = {hdr_reg[14:0], disk_bit};
    assign data_bits   = `DCT_SECTOR_BYTES * 12'd8;
    assign sector_bits = data_bits + `DCT_CRC_BITS;
    assign sector_inc  = addr_reg[5:0] + 6'h01;
    assign ack_ok      = dreq_reg & dma_ack;

    // Header bytes feed the packer only for a header read; data feeds
    // all 256 bytes, the packer itself trims the 12-bit tail
    assign feed = ((state_reg == S_HDR) && (fn == `DCT_FN_RDHDR)) ||
                  ((state_reg == S_DATA) && (bcnt_reg < data_bits));
    assign pk_valid = disk_bit_valid & feed;

    dct_packer dct_packer_inst (
        .pclk       (pclk),
        .presetn    (presetn),
        .clear      (pk_clear),
        .byte_mode  (byte_mode),
        .bit_valid  (pk_valid),
        .bit_in     (disk_bit),
        .word_valid (pk_word_valid),
        .word_out   (pk_word)
    );

    // Per-drive seek tracking; seeks on all four drives may overlap,
    // a new start beats a done pulse in the same cycle
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_seek
            assign seeking_next[gi] = start_reg[gi] | (seeking_reg[gi] & ~seek_done[gi]);
        end
    endgenerate

    always @* begin
        state_next  = state_reg;
        cmd_next    = cmd_reg;
        addr_next   = addr_reg;
        wcnt_next   = wcnt_reg;
        seek_next   = seek_reg;
        done_next   = done_reg;
        err_next    = err_reg;
        start_next  = 4'h0;
        bcnt_next   = bcnt_reg;
        crc_next    = crc_reg;
        hdr_next    = hdr_reg;
        search_next = search_reg;
        pk_clear    = 1'b0;
        dreq_next   = dreq_reg;
        dword_next  = dword_reg;
        rdata_next  = rdata_reg;

        if (wr_en && paddr == `DCT_OFF_ADDR && !busy)
            addr_next = pwdata[15:0];
        if (wr_en && paddr == `DCT_OFF_WCNT && !busy)
            wcnt_next = pwdata[11:0];
        if (wr_en && paddr == `DCT_OFF_SEEK && !busy)
            seek_next = pwdata[10:0];

        if (rd_setup) begin
            case (paddr)
                `DCT_OFF_CMD:    rdata_next = {25'h0, cmd_reg};
                `DCT_OFF_ADDR:   rdata_next = {16'h0, addr_reg};
                `DCT_OFF_WCNT:   rdata_next = {20'h0, wcnt_reg};
                `DCT_OFF_SEEK:   rdata_next = {21'h0, seek_reg};
                `DCT_OFF_STATUS: rdata_next = {20'h0, seeking_reg, busy,
                                               1'b0, err_reg, done_reg};
                default:         rdata_next = 32'h0000_0000;
            endcase
        end

        // DMA holding word; a new word before the last was taken is late
        if (ack_ok) begin
            dreq_next = 1'b0;
            wcnt_next = wcnt_reg + 12'd1;
        end
        if (pk_word_valid) begin
            dreq_next  = 1'b1;
            dword_next = pk_word;
            if (dreq_reg && !dma_ack)
                err_next[4] = 1'b1;
        end

        case (state_reg)
            S_IDLE: begin
                if (cmd_wr) begin
                    cmd_next    = pwdata[6:0];
                    done_next   = 1'b0;
                    // A late word in the same cycle still flags
                    err_next    = {pk_word_valid & dreq_reg & ~dma_ack, 4'h0};
                    search_next = 8'h00;
                    dreq_next   = 1'b0;
                    case (pwdata[2:0])
                        `DCT_FN_SEEK: begin
                            // Issued even with zero difference, so a pure
                            // head switch re-centres on the new track
                            start_next[pwdata[4:3]] = 1'b1;
                            done_next = 1'b1;
                        end
                        `DCT_FN_RDHDR,
                        `DCT_FN_RDDATA,
                        `DCT_FN_RDNOCHK:
                            state_next = S_WSEEK;
                        default:
                            done_next = 1'b1;
                    endcase
                end
            end
            S_WSEEK: begin
                // Transfer waits for its own drive to settle
                if (hdr_mark && !seeking_reg[drv]) begin
                    if (search_reg == `DCT_SEARCH_LIMIT) begin
                        err_next[0] = 1'b1;
                        state_next  = S_IDLE;
                    end else begin
                        search_next = search_reg + 8'h01;
                        bcnt_next   = 12'h000;
                        crc_next    = 16'h0000;
                        pk_clear    = 1'b1;
                        state_next  = S_HDR;
                    end
                end
            end
            S_HDR: begin
                if (disk_bit_valid) begin
                    crc_next  = crc_step;
                    bcnt_next = bcnt_reg + 12'd1;
                    if (bcnt_reg < `DCT_ADDR_BITS)
                        hdr_next = hdr_shift;
                    if (bcnt_reg == `DCT_HDR_BITS - 12'd1) begin
                        if (fn == `DCT_FN_RDNOCHK) begin
                            state_next = S_DWAIT;
                        end else if (crc_step != 16'h0000) begin
                            err_next[2] = 1'b1;
                            state_next  = S_IDLE;
                        end else if (fn == `DCT_FN_RDHDR) begin
                            state_next = S_IDLE;
                        end else if (hdr_reg == addr_reg) begin
                            state_next = S_DWAIT;
                        end else begin
                            state_next = S_WSEEK;
                        end
                    end
                end
            end
            S_DWAIT: begin
                if (data_mark) begin
                    bcnt_next  = 12'h000;
                    crc_next   = 16'h0000;
                    pk_clear   = 1'b1;
                    state_next = S_DATA;
                end
            end
            S_DATA: begin
                if (disk_bit_valid) begin
                    crc_next  = crc_step;
                    bcnt_next = bcnt_reg + 12'd1;
                    if (bcnt_reg == sector_bits - 12'd1) begin
                        if (crc_step != 16'h0000) begin
                            err_next[3] = 1'b1;
                            state_next  = S_IDLE;
                        end else begin
                            addr_next[5:0] = sector_inc;
                            search_next    = 8'h00;
                            if (sector_inc == `DCT_SECTOR_LIMIT) begin
                                err_next[0] = 1'b1;
                                state_next  = S_IDLE;
                            end else begin
                                state_next = S_WSEEK;
                            end
                        end
                    end
                end
            end
            default: state_next = S_IDLE;
        endcase

        // Word count exhausted ends any transfer
        if (busy && ack_ok && wcnt_reg == 12'hFFF)
            state_next = S_IDLE;
        if (err_next != 5'h00 && busy)
            state_next = S_IDLE;
        if (busy && state_next == S_IDLE)
            done_next = 1'b1;
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg  <= S_IDLE;
            cmd_reg    <= `DCT_RST_CMD;
            addr_reg   <= `DCT_RST_ADDR;
            wcnt_reg   <= `DCT_RST_WCNT;
            seek_reg   <= `DCT_RST_SEEK;
            done_reg   <= 1'b0;
            err_reg    <= 5'h00;
            start_reg  <= 4'h0;
            bcnt_reg   <= 12'h000;
            crc_reg    <= 16'h0000;
            hdr_reg    <= 16'h0000;
            search_reg <= 8'h00;
            dreq_reg   <= 1'b0;
            dword_reg  <= 12'h000;
            rdata_reg  <= 32'h0000_0000;
            seeking_reg <= 4'h0;
        end else begin
            state_reg  <= state_next;
            cmd_reg    <= cmd_next;
            addr_reg   <= addr_next;
            wcnt_reg   <= wcnt_next;
            seek_reg   <= seek_next;
            done_reg   <= done_next;
            err_reg    <= err_next;
            start_reg  <= start_next;
            bcnt_reg   <= bcnt_next;
            crc_reg    <= crc_next;
            hdr_reg    <= hdr_next;
            search_reg <= search_next;
            dreq_reg   <= dreq_next;
            dword_reg  <= dword_next;
            rdata_reg  <= rdata_next;
            seeking_reg <= seeking_next;
        end
    end

    assign drive_sel  = drv;
    assign seek_start = start_reg;
    assign seek_diff  = seek_reg[`DCT_SEEK_DIFF_MSB:0];
    assign seek_dir   = seek_reg[`DCT_SEEK_DIR_BIT];
    assign seek_head  = seek_reg[`DCT_SEEK_HEAD_BIT];
    assign dma_req    = dreq_reg;
    assign dma_word   = dword_reg;
endmodule

// [tb/dct_ctrl_checker.sv]
`timescale 1ns/1ps
`include "dct_defines.vh"
module dct_ctrl_checker (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        irq,
    input wire [3:0]  seek_start,
    input wire        dma_req,
    input wire [11:0] dma_word,
    input wire        dma_ack
);
    wire acc  = psel && penable;
    wire wcmd = acc && pwrite && paddr == `DCT_OFF_CMD;
    wire unm  = paddr > `DCT_OFF_STATUS || paddr[1:0] != 2'h0;
    // Mirrors of the last command; only valid because commands go in while idle
    reg       bm_reg;
    reg       ie_reg;
    reg [3:0] sk_reg;
    always @(posedge pclk or negedge presetn)
        if (!presetn) begin
            bm_reg <= 1'b0;
            ie_reg <= 1'b0;
            sk_reg <= 4'h0;
        end else if (wcmd) begin
            bm_reg <= pwdata[`DCT_CMD_BYTE_BIT];
            ie_reg <= pwdata[`DCT_CMD_IE_BIT];
            sk_reg <= 4'h1 << pwdata[4:3];
        end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_err_decode: assert property (acc |-> pslverr == unm)
        else $error("pslverr decode wrong");
    chk_read_unmapped: assert property (acc && !pwrite && unm |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_byte_upper: assert property (dma_req && bm_reg |-> dma_word[11:8] == 4'h0)
        else $error("byte word upper bits set");
    chk_word_stands: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_word))
        else $error("dma word moved before ack");
    chk_ack_drops: assert property (dma_req && dma_ack |=> !dma_req)
        else $error("dma request held after ack");
    chk_seek_pulse: assert property (|seek_start |-> seek_start == sk_reg ##1 !seek_start)
        else $error("seek start pulse wrong");
    chk_irq_enable: assert property (irq |-> ie_reg)
        else $error("irq without enable");
    chk_irq_clear: assert property (wcmd && !pwdata[`DCT_CMD_IE_BIT] |=> !irq [*2])
        else $error("irq not cleared by command");
    chk_irq_holds: assert property (irq && !wcmd |=> irq)
        else $error("irq dropped without command");
    cover property (|seek_start);
    cover property (dma_req && dma_ack);
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule

bind dct_ctrl dct_ctrl_checker dct_ctrl_checker_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .seek_start(seek_start), .dma_req(dma_req), .dma_word(dma_word),
    .dma_ack(dma_ack)
);

// [tb/dct_dma_host.sv]
`timescale 1ns/1ps
module dct_dma_host (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        clr,
    input  wire [1:0]  lag,
    input  wire        dma_req,
    input  wire [11:0] dma_word,
    output reg         dma_ack
);
    reg [11:0] mem [0:511];
    reg [9:0]  n_word;
    reg [1:0]  wait_reg;
    // Ack lasts one edge so a held word is never stored twice
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ack  <= 1'b0;
            n_word   <= 10'h0;
            wait_reg <= 2'h0;
        end else if (dma_ack || clr) begin
            dma_ack <= 1'b0;
            if (clr) n_word <= 10'h0;
        end else if (dma_req && wait_reg >= lag) begin
            dma_ack          <= 1'b1;
            mem[n_word[8:0]] <= dma_word;
            n_word           <= n_word + 10'h1;
            wait_reg         <= 2'h0;
        end else if (dma_req) begin
            wait_reg <= wait_reg + 2'h1;
        end
    end
endmodule

// [tb/testbench.sv]
`timescale 1ns/1ps
`include "dct_defines.vh"
module testbench;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
    logic        disk_bit, disk_bit_valid, hdr_mark, data_mark, dma_req, dma_ack, clr;
    logic        seek_dir, seek_head;
    logic [1:0]  drive_sel, lag;
    logic [3:0]  seek_start, seek_done;
    logic [7:0]  paddr;
    logic [8:0]  seek_diff;
    logic [11:0] dma_word;
    logic [15:0] crc;
    logic [31:0] pwdata, prdata, rdata;
    integer      n_mismatch = 0;
    integer      checks = 0;
    integer      k;

    dct_ctrl dct_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq(irq), .disk_bit(disk_bit), .disk_bit_valid(disk_bit_valid), .hdr_mark(hdr_mark),
        .data_mark(data_mark), .drive_sel(drive_sel), .seek_start(seek_start),
        .seek_diff(seek_diff), .seek_dir(seek_dir), .seek_head(seek_head),
        .seek_done(seek_done), .dma_req(dma_req), .dma_word(dma_word), .dma_ack(dma_ack)
    );
    dct_dma_host dct_dma_host_inst (
        .pclk(pclk), .presetn(presetn), .clr(clr), .lag(lag), .dma_req(dma_req),
        .dma_word(dma_word), .dma_ack(dma_ack)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task apb(input [7:0] a, input w, input [31:0] d);
        integer j;
        begin
            psel   <= 1'b1;
            paddr  <= a;
            pwrite <= w;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            j = 0;
            do begin
                @(posedge pclk);
                j++;
            end while (pready !== 1'b1 && j < 50);
            if (pready !== 1'b1) begin
                n_mismatch++;
                end_of_test;
            end
            rdata = prdata;
            rerr  = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // Polls until done so slow acknowledges do not need a fixed wait
    task stat(input [31:0] m, input [31:0] e);
        integer j;
        begin
            for (j = 0; j < 20; j++) begin
                apb(`DCT_OFF_STATUS, 1'b0, 32'h0);
                if (rdata[0] === 1'b1) break;
            end
            chk("status", rdata & m, e);
        end
    endtask

    task go(input [15:0] ad, input [11:0] wc, input [6:0] cmd);
        apb(`DCT_OFF_ADDR, 1'b1, {16'h0, ad});
        clr <= 1'b1;
        apb(`DCT_OFF_WCNT, 1'b1, {20'h0, wc});
        clr <= 1'b0;
        apb(`DCT_OFF_CMD, 1'b1, {25'h0, cmd});
    endtask

    task send(input [15:0] v, input integer n);
        integer i;
        for (i = n - 1; i >= 0; i--) begin
            disk_bit       <= v[i];
            disk_bit_valid <= 1'b1;
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ v[i]) ? `DCT_CRC_POLY : 16'h0);
            @(posedge pclk);
        end
    endtask

    // A set bad flag corrupts the last check bit of the field
    task field(input hdr, input [15:0] ad, input bad, input [7:0] sd);
        integer i;
        begin
            if (hdr) hdr_mark <= 1'b1;
            else data_mark <= 1'b1;
            @(posedge pclk);
            hdr_mark  <= 1'b0;
            data_mark <= 1'b0;
            crc = 16'h0;
            if (hdr) send(ad, 16);
            if (hdr) send(16'h0, 16);
            else for (i = 0; i < 256; i++) send({8'h0, i[7:0] ^ sd}, 8);
            send(crc ^ {15'h0, bad}, 16);
            disk_bit_valid <= 1'b0;
            disk_bit       <= ~disk_bit;
            repeat (8) @(posedge pclk);
        end
    endtask

    function [11:0] w12(input integer n, input [7:0] sd);
        integer b, p;
        reg [7:0] t;
        for (b = 0; b < 12; b++) begin
            p = 12 * n + b;
            t = p[10:3] ^ sd;
            w12[11 - b] = t[7 - p[2:0]];
        end
    endfunction

    task words(input integer n, input md, input [7:0] sd);
        integer j;
        reg [7:0] b;
        begin
            chk("word count", dct_dma_host_inst.n_word, n);
            for (j = 0; j < n; j++) begin
                b = j[7:0] ^ sd;
                chk("dma word", dct_dma_host_inst.mem[j], md ? w12(j, sd) : {4'h0, b});
            end
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {disk_bit, disk_bit_valid, hdr_mark, data_mark, clr, lag, seek_done} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(`DCT_OFF_STATUS, 1'b0, 32'h0);
        chk("reset status", rdata, 32'h0);
        apb(8'h14, 1'b1, 32'hFFF);
        chk("slverr", rerr, 1'b1);
        apb(8'h14, 1'b0, 32'h0);
        chk("unmapped read", rdata, 32'h0);
        apb(`DCT_OFF_CMD, 1'b1, 32'h40);
        stat(32'hFFF, 32'h1);
        chk("irq", irq, 1'b1);
        repeat (5) @(posedge pclk);
        chk("irq held", irq, 1'b1);
        apb(`DCT_OFF_CMD, 1'b1, 32'h0);
        chk("irq masked", irq, 1'b0);
        go(16'h02C3, 12'hF00, 7'h66);
        field(1'b1, 16'h02C2, 1'b0, 8'h0);
        field(1'b1, 16'h02C3, 1'b0, 8'h0);
        field(1'b0, 16'h0, 1'b0, 8'h3C);
        words(256, 1'b0, 8'h3C);
        stat(32'hFFF, 32'h1);
        lag <= 2'h3;
        go(16'h0, 12'hF56, 7'h07);
        field(1'b1, 16'hFFFF, 1'b1, 8'h0);
        field(1'b0, 16'h0, 1'b0, 8'h5A);
        words(170, 1'b1, 8'h5A);
        stat(32'hFFF, 32'h1);
        lag <= 2'h0;
        go(16'h0, 12'hEFF, 7'h27);
        field(1'b1, 16'h1234, 1'b1, 8'h0);
        field(1'b0, 16'h0, 1'b1, 8'h11);
        stat(32'h3, 32'h1);
        chk("crc flags", rdata[4:3], 2'b10);
        go(16'h02E7, 12'hE00, 7'h66);
        field(1'b1, 16'h02E7, 1'b0, 8'h0);
        field(1'b0, 16'h0, 1'b0, 8'h77);
        words(256, 1'b0, 8'h77);
        stat(32'hBF, 32'h3);
        chk("irq", irq, 1'b1);
        go(16'h02C3, 12'hF00, 7'h26);
        for (k = 0; k < 81; k++) field(1'b1, 16'h02C1, 1'b0, 8'h0);
        stat(32'hBF, 32'h3);
        go(16'h02C3, 12'hF00, 7'h24);
        field(1'b1, 16'h02C1, 1'b0, 8'h0);
        stat(32'hFFF, 32'h1);
        chk("header words", dct_dma_host_inst.n_word, 6);
        chk("header cylinder", dct_dma_host_inst.mem[0], 12'h002);
        chk("header sector", dct_dma_host_inst.mem[1], 12'h0C1);
        chk("header spare", dct_dma_host_inst.mem[2], 12'h000);
        apb(`DCT_OFF_SEEK, 1'b1, 32'h400);
        apb(`DCT_OFF_CMD, 1'b1, 32'h13);
        chk("head", seek_head, 1'b1);
        apb(`DCT_OFF_SEEK, 1'b1, 32'h205);
        apb(`DCT_OFF_CMD, 1'b1, 32'h0B);
        chk("seek diff", seek_diff, 9'h005);
        chk("seek dir", seek_dir, 1'b1);
        chk("drive select", drive_sel, 2'h1);
        stat(32'hFFF, 32'h601);
        seek_done <= 4'h4;
        @(posedge pclk);
        seek_done <= 4'h0;
        stat(32'hF00, 32'h200);
        end_of_test;
    end
endmodule
